/* src/sdo_consts.svh */
// Purpose: Shared constants of the SD-rate oversampling datapath.
// Assumes: 20 oversampled line samples per receive user clock cycle, sample 0 first in time.
// Notes: Included by the package and by the datapath module.
// Function
// - In SD receive mode a one-cycle word enable averaging 27 MHz is made, normally 5 and 6 cycles apart.
// - The data recovery unit raises a strobe each time a complete 10-bit word stands on its output.
// - The exported word enable is made from the recovery strobe and keeps exactly its cadence.
// - A pair of enable gaps may total 10 or 12 cycles instead of 11 to absorb rate offset.
// - Received words are qualified only by the word enable, never by the clock itself.
// - SD transmit runs the line at 2.97 Gb/s and repeats every outgoing bit 11 times.
// - The recovered-clock pattern makes a 270 MHz square wave locked to the incoming stream.
// - Pattern edges move by one line bit time either way to follow the input bit rate.
// - The recovered-clock pattern is internal and reaches a port only when enabled.
// - In SD receive mode the clock-data-recovery hold output is held high.
// - The data recovery unit oversamples exactly 11 times and supports no other SD rate.
`ifndef SDO_CONSTS_SVH
`define SDO_CONSTS_SVH

`define SDO_SAMPLES 20
`define SDO_WORD_BITS 10
`define SDO_OVERSAMPLE 4'hB
`define SDO_PH_LAST 4'hA
`define SDO_PH_CENTER 4'h5
`define SDO_PH_LATE_MAX 4'h4
`define SDO_PH_HIGH 4'h6
`define SDO_BIT_LAST 4'h9
`define SDO_TXQ_BITS 20
`define SDO_TXQ_ROOM 5'h0A
`define SDO_FIFO_DEPTH 16

`endif

/* src/sdo_pkg.sv */
// Purpose: Types of the SD-rate oversampling datapath.
// Assumes: Constants come from the shared header.
// Notes: Holds the state record of the main module.
`include "sdo_consts.svh"

package sdo_pkg;

   typedef struct packed {
      logic [3:0] ph;
      logic prev;
      logic [9:0] shift;
      logic [3:0] bit_cnt;
      logic [9:0] word;
      logic stb;
      logic [19:0] recclk;
      logic [19:0] txq;
      logic [4:0] txq_cnt;
      logic [3:0] tx_rep;
      logic [19:0] txd;
      logic hold;
   } sdo_state_s;

endpackage

/* src/sdo_fifo.sv */
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; DEPTH is a power of two.
// Notes: Pointers carry one wrap bit so full and empty are exact.
`timescale 1ns/1ps

module sdo_fifo #(
   parameter int W = 10,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } sdo_fifo_s;

   sdo_fifo_s r_reg;
   sdo_fifo_s r_next;
   logic [W-1:0] mem [DEPTH];
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign empty = (r_reg.wp == r_reg.rp);
   assign full = (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]) && (r_reg.wp[AW] != r_reg.rp[AW]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[r_reg.rp[AW-1:0]];
   assign push = in_valid_i && !full;
   assign pop = out_ready_i && !empty;

   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.wp = r_reg.wp + 1'b1;
      end
      if (pop) begin
         r_next.rp = r_reg.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   // Storage needs no reset; empty flag masks stale words
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[r_reg.wp[AW-1:0]] <= in_data_i;
      end
   end

endmodule

/* src/sdo_datapath.sv */
// Purpose: SD-rate receive recovery, 11x transmit replication and recovered-clock pattern.
// Assumes: Runs on the receive user clock; 20 line samples per cycle, sample 0 oldest.
// Notes: Words go out LSB first; the transmit side is fed through a FIFO with back-pressure.
`timescale 1ns/1ps
`include "sdo_consts.svh"

module sdo_datapath #(
   parameter bit EXPORT_RECCLK = 1'b0,
   parameter int FIFO_DEPTH = `SDO_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic sd_mode_i,
   input wire logic [19:0] rx_samples_i,
   output logic [9:0] rx_word_o,
   output logic rx_word_enable_o,
   output logic cdr_hold_o,
   output logic tx_rate_3g_o,
   input wire logic [9:0] tx_word_i,
   input wire logic tx_word_valid_i,
   output logic tx_word_ready_o,
   output logic [19:0] tx_samples_o,
   output logic [19:0] rec_clk_pattern_o
);

   //***************************************************************
   // State and transmit FIFO
   //***************************************************************
   sdo_pkg::sdo_state_s r_reg;
   sdo_pkg::sdo_state_s r_next;
   logic sd_word_enable_internal;
   logic [9:0] fifo_word;
   logic fifo_valid;
   logic fifo_pop;

   sdo_fifo #(
      .W(`SDO_WORD_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .in_data_i(tx_word_i),
      .in_valid_i(tx_word_valid_i),
      .in_ready_o(tx_word_ready_o),
      .out_data_o(fifo_word),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop)
   );

   // Pull a word while at least ten queue places are free
   assign fifo_pop = sd_mode_i && fifo_valid && (r_reg.txq_cnt <= `SDO_TXQ_ROOM);

   //***************************************************************
   // Next-state logic
   //***************************************************************
   always_comb begin
      logic [3:0] ph;
      logic adjusted;
      logic s;
      logic [19:0] q;
      logic [4:0] qc;
      logic [3:0] rep;
      ph = r_reg.ph;
      adjusted = 1'b0;
      s = 1'b0;
      q = r_reg.txq;
      qc = r_reg.txq_cnt;
      rep = r_reg.tx_rep;
      r_next = r_reg;
      r_next.stb = 1'b0;
      r_next.hold = sd_mode_i;

      if (!sd_mode_i) begin
         r_next.ph = 4'h0;
         r_next.bit_cnt = 4'h0;
         r_next.recclk = 20'h00000;
         r_next.txq = 20'h00000;
         r_next.txq_cnt = 5'h00;
         r_next.tx_rep = 4'h0;
         r_next.txd = 20'h00000;
      end else begin
         // Receive: one decision per 11 samples at the eye centre
         for (int i = 0; i < `SDO_SAMPLES; i++) begin
            s = rx_samples_i[i];
            r_next.recclk[i] = (ph < `SDO_PH_HIGH);
            if (ph == `SDO_PH_CENTER) begin
               r_next.shift = {s, r_next.shift[9:1]};
               if (r_next.bit_cnt == `SDO_BIT_LAST) begin
                  r_next.word = r_next.shift;
                  r_next.stb = 1'b1;
                  r_next.bit_cnt = 4'h0;
               end else begin
                  r_next.bit_cnt = r_next.bit_cnt + 4'h1;
               end
            end
            // One phase step per cycle at most keeps the pattern jitter to one bit
            if (s != r_next.prev && !adjusted && ph != 4'h0) begin
               adjusted = 1'b1;
               if (ph <= `SDO_PH_LATE_MAX) begin
                  ph = ph;
               end else begin
                  ph = (ph >= 4'h9) ? ph - 4'h9 : ph + 4'h2;
               end
            end else begin
               ph = (ph == `SDO_PH_LAST) ? 4'h0 : ph + 4'h1;
            end
            r_next.prev = s;
         end
         r_next.ph = ph;

         // Transmit: every bit held for 11 consecutive samples
         for (int i = 0; i < `SDO_SAMPLES; i++) begin
            r_next.txd[i] = q[0];
            // Idle queue parks the repeat count so a new word starts on a full bit
            if (qc == 5'h00) begin
               rep = 4'h0;
            end else if (rep == `SDO_PH_LAST) begin
               rep = 4'h0;
               if (qc != 5'h00) begin
                  q = {1'b0, q[19:1]};
                  qc = qc - 5'h01;
               end
            end else begin
               rep = rep + 4'h1;
            end
         end
         if (fifo_pop) begin
            q = q | ({10'h000, fifo_word} << qc);
            qc = qc + 5'h0A;
         end
         r_next.txq = q;
         r_next.txq_cnt = qc;
         r_next.tx_rep = rep;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   //***************************************************************
   // Outputs
   //***************************************************************
   // Enable is the registered recovery strobe itself, so the cadence is kept
   assign sd_word_enable_internal = r_reg.stb;
   assign rx_word_enable_o = sd_word_enable_internal;
   assign rx_word_o = r_reg.word;
   assign cdr_hold_o = r_reg.hold;
   assign tx_rate_3g_o = r_reg.hold;
   assign tx_samples_o = r_reg.txd;
   // Pattern stays internal unless the parameter brings it out
   assign rec_clk_pattern_o = EXPORT_RECCLK ? r_reg.recclk : 20'h00000;

endmodule

/* dv/sdo_line_model.sv */
// Purpose: Line model giving an 11x oversampled word stream.
// Assumes: Stream restarts at phase 0 when SD mode rises.
// Notes: Word n is 10'h155 xor n*37, LSB first; drift 1 adds, 2 drops one sample per 110.
`timescale 1ns/1ps
module sdo_line_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic sd_mode_i,
   input wire logic [1:0] drift_i,
   output logic [19:0] rx_samples_o
);
   logic [15:0] cyc_reg;
   logic [9:0] w;
   int s;
   int p;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cyc_reg <= 16'h0000;
      end else begin
         cyc_reg <= sd_mode_i ? cyc_reg + 16'h0001 : 16'h0000;
      end
   end
   // Eleven samples per bit, optionally a slow or fast line
   // Runs on the receiver's own clock, as the spare transmitter would
   always_comb begin
      for (int i = 0; i < 20; i++) begin
         s = int'(cyc_reg) * 20 + i;
         p = (drift_i == 2'h1) ? s - s / 110 : ((drift_i == 2'h2) ? s + s / 110 : s);
         w = 10'h155 ^ 10'(p / 110 * 37);
         rx_samples_o[i] = w[(p / 11) % 10];
      end
   end
endmodule

/* dv/sdo_datapath_assertions.sv */
// Purpose: Port checker of the SD datapath.
// Assumes: One clock, reset active low.
// Notes: Gap history restarts when SD mode drops.
`timescale 1ns/1ps
module sdo_datapath_assertions #(
   parameter bit EXPORT_RECCLK = 1'b0
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic sd_mode_i,
   input wire logic [9:0] rx_word_o,
   input wire logic rx_word_enable_o,
   input wire logic cdr_hold_o,
   input wire logic tx_rate_3g_o,
   input wire logic [19:0] tx_samples_o,
   input wire logic [19:0] rec_clk_pattern_o
);
   // ****
   // Gap history
   // ****
   logic [4:0] gap_reg;
   logic [4:0] last_reg;
   logic [1:0] seen_reg;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gap_reg <= 5'h00;
         last_reg <= 5'h00;
         seen_reg <= 2'h0;
      end else if (!sd_mode_i) begin
         gap_reg <= 5'h00;
         last_reg <= 5'h00;
         seen_reg <= 2'h0;
      end else if (rx_word_enable_o) begin
         gap_reg <= 5'h01;
         last_reg <= gap_reg;
         seen_reg <= seen_reg + 2'(seen_reg != 2'h3);
      end else if (gap_reg != 5'h1F) begin
         gap_reg <= gap_reg + 5'h01;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_on; sd_mode_i [*2]; endsequence
   sequence s_off; !sd_mode_i [*2]; endsequence
   property p_pulse; rx_word_enable_o |=> !rx_word_enable_o; endproperty
   a_pulse: assert property (p_pulse) else $error("enable longer than one cycle");
   property p_gap; rx_word_enable_o && seen_reg != 2'h0 |-> gap_reg inside {[4:7]}; endproperty
   a_gap: assert property (p_gap) else $error("enable gap out of range");
   property p_pair;
      rx_word_enable_o && seen_reg[1] |-> (gap_reg + last_reg) inside {[10:12]};
   endproperty
   a_pair: assert property (p_pair) else $error("enable pair out of range");
   property p_steady; sd_mode_i && seen_reg != 2'h0 |-> gap_reg < 5'h08; endproperty
   a_steady: assert property (p_steady) else $error("enable cadence stopped");
   property p_word; s_on ##0 !rx_word_enable_o |-> $stable(rx_word_o); endproperty
   a_word: assert property (p_word) else $error("word moved without enable");
   property p_hold; s_on |-> cdr_hold_o && tx_rate_3g_o; endproperty
   a_hold: assert property (p_hold) else $error("hold or rate low in SD mode");
   property p_drop; !sd_mode_i |=> !cdr_hold_o && !rx_word_enable_o; endproperty
   a_drop: assert property (p_drop) else $error("activity after SD mode off");
   property p_idle; s_off |=> tx_samples_o == 20'h00000; endproperty
   a_idle: assert property (p_idle) else $error("line samples while idle");
   property p_rec; EXPORT_RECCLK || rec_clk_pattern_o == 20'h00000; endproperty
   a_rec: assert property (p_rec) else $error("pattern exported while disabled");
endmodule
bind sdo_datapath sdo_datapath_assertions #(.EXPORT_RECCLK(EXPORT_RECCLK)) u_chk (
   .clk_i(clk_i), .rstn_i(rstn_i), .sd_mode_i(sd_mode_i), .rx_word_o(rx_word_o),
   .rx_word_enable_o(rx_word_enable_o), .cdr_hold_o(cdr_hold_o), .tx_rate_3g_o(tx_rate_3g_o),
   .tx_samples_o(tx_samples_o), .rec_clk_pattern_o(rec_clk_pattern_o));

/* dv/sdo_datapath_bench.sv */
// Purpose: Self-checking bench of the SD datapath.
// Assumes: Default parameters, FIFO of 16 words.
// Notes: Transmit stream is aligned on its first high sample.
`timescale 1ns/1ps
module sdo_datapath_bench;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic sd_mode_i = 1'b0;
   logic [1:0] drift_i = 2'h0;
   logic tx_word_valid_i = 1'b0;
   logic [9:0] tx_word_i = 10'h000;
   logic [19:0] rx_samples_i, tx_samples_o, rec_clk_pattern_o;
   logic [9:0] rx_word_o;
   logic rx_word_enable_o, cdr_hold_o, tx_rate_3g_o, tx_word_ready_o;
   logic q[$];
   int n_errors = 0;
   int n_tests = 0;
   always #5 clk_i = ~clk_i;
   sdo_datapath u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .sd_mode_i(sd_mode_i),
      .rx_samples_i(rx_samples_i), .rx_word_o(rx_word_o), .rx_word_enable_o(rx_word_enable_o),
      .cdr_hold_o(cdr_hold_o), .tx_rate_3g_o(tx_rate_3g_o), .tx_word_i(tx_word_i),
      .tx_word_valid_i(tx_word_valid_i), .tx_word_ready_o(tx_word_ready_o),
      .tx_samples_o(tx_samples_o), .rec_clk_pattern_o(rec_clk_pattern_o));
   sdo_line_model u_line (.clk_i(clk_i), .rstn_i(rstn_i), .sd_mode_i(sd_mode_i),
      .drift_i(drift_i), .rx_samples_o(rx_samples_i));
   // ****
   // Helpers
   // ****
   function automatic logic [9:0] tx_val(int k);
      return {4'(k), 6'h2B};
   endfunction
   task automatic check(string what, logic [19:0] exp, logic [19:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic test_fill();
      int n;
      n = 0;
      for (int k = 0; k < 20; k++) begin
         tx_word_i <= tx_val(n);
         tx_word_valid_i <= 1'b1;
         @(posedge clk_i);
         if (tx_word_ready_o === 1'b1) n++;
      end
      tx_word_valid_i <= 1'b0;
      check("words held", 20'h00010, 20'(n));
      check("ready when full", 20'h00000, {19'h0, tx_word_ready_o});
      $display("test fill done");
   endtask
   task automatic test_tx();
      int bad;
      logic [9:0] e;
      bad = 0;
      sd_mode_i <= 1'b1;
      for (int c = 0; c < 100; c++) begin
         @(posedge clk_i);
         for (int i = 0; i < 20; i++) q.push_back(tx_samples_o[i]);
      end
      while (q.size() > 0 && q[0] !== 1'b1) q.pop_front();
      if (q.size() < 1800) bad++;
      for (int j = 0; j < q.size(); j++) begin
         e = tx_val(j / 110);
         if (q[j] !== (j < 1760 ? e[(j / 11) % 10] : 1'b0)) bad++;
      end
      check("tx bits", 20'h00000, 20'(bad));
      check("tx rate", 20'h00001, {19'h0, tx_rate_3g_o});
      check("pattern hidden", 20'h00000, rec_clk_pattern_o);
      $display("test tx done");
   endtask
   // Line rate set by drift; exp_pair is the enable pair total that must show up
   task automatic test_rx(logic [1:0] drift, int exp_pair);
      int n;
      int gap;
      int last;
      int hits;
      n = 0;
      gap = 0;
      last = 0;
      hits = 0;
      sd_mode_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      drift_i <= drift;
      sd_mode_i <= 1'b1;
      for (int c = 0; c < 300 && n < 24; c++) begin
         @(posedge clk_i);
         gap++;
         if (rx_word_enable_o === 1'b1) begin
            check("rx word", {10'h0, 10'h155 ^ 10'(n * 37)}, {10'h0, rx_word_o});
            if (n >= 2 && gap + last == exp_pair) hits++;
            last = gap;
            gap = 0;
            n++;
         end
      end
      check("rx words", 20'h00018, 20'(n));
      check("rx pair", 20'h00001, {19'h0, hits > 0});
      $display("test rx done");
   endtask
   task automatic test_off();
      int bad;
      bad = 0;
      sd_mode_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (int c = 0; c < 12; c++) begin
         @(posedge clk_i);
         if (rx_word_enable_o !== 1'b0) bad++;
      end
      check("enable off", 20'h00000, 20'(bad));
      check("hold off", 20'h00000, {19'h0, cdr_hold_o});
      check("rate off", 20'h00000, {19'h0, tx_rate_3g_o});
      $display("test off done");
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      test_fill();
      test_tx();
      test_rx(2'h0, 11);
      test_rx(2'h1, 12);
      test_rx(2'h2, 10);
      test_off();
      stop_test();
   end
endmodule
